// file: common/acb_pkg.sv
// command block decoder package: offsets, field positions, states and carriers
// assumes AXI4-Lite byte addressing with 32-bit data
package acb_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CB0    = 8'h10;
  localparam logic [7:0] OFS_CB3    = 8'h1C;
  localparam logic [7:0] OFS_RB0    = 8'h20;
  localparam logic [7:0] OFS_RB1    = 8'h24;

  // ==========================================================
  // field positions and reset values
  localparam int          CTRL_DEV_BIT    = 8;
  localparam int          CMD_GO_BIT      = 0;
  localparam logic [7:0]  CTRL_SIG_RESET  = 8'h00;
  localparam logic [7:0]  SUBCMD_ATA      = 8'h24;
  localparam int          ACT_IDENTIFY    = 7;
  localparam int          ACT_UDMA        = 6;
  localparam int          ACT_DEV_SRC     = 5;
  localparam int          ACT_HALT_DEV    = 4;
  localparam int          ACT_HALT_PHASE  = 3;
  localparam int          ACT_SKIP_POLL   = 2;
  localparam int          ACT_SEL_AFTER   = 1;
  localparam int          ACT_READBACK    = 0;
  localparam int          CB_ACTION       = 2;
  localparam int          CB_REGSEL       = 3;
  localparam int          CB_BLKCNT       = 4;
  localparam int          CB_WR_BASE      = 5;
  localparam int          CB_DEVICE       = 11;
  localparam int          DEVHEAD_DEV_BIT = 4;
  localparam int          BSY_BIT         = 7;
  localparam logic [2:0]  REG_ALTSTAT     = 3'h0;
  localparam logic [2:0]  REG_DEVHEAD     = 3'h6;
  localparam logic [2:0]  REG_LAST        = 3'h7;
  localparam logic [8:0]  BLK_ZERO_MEANS  = 9'h100;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_CHECK     = 4'b0001,
    ST_POLL_REQ  = 4'b0010,
    ST_POLL_WAIT = 4'b0011,
    ST_ACC_REQ   = 4'b0100,
    ST_ACC_WAIT  = 4'b0101,
    ST_SEL_REQ   = 4'b0110,
    ST_SEL_WAIT  = 4'b0111,
    ST_XFER      = 4'b1000,
    ST_XFER_WAIT = 4'b1001,
    ST_DONE      = 4'b1010
  } acb_state_t;

  // ==========================================================
  // carriers toward the taskfile engine and the data mover
  typedef struct packed {
    logic       we;
    logic [2:0] reg_idx;
    logic [7:0] wdata;
  } acb_tf_req_t;

  typedef struct packed {
    logic       udma;
    logic       identify;
    logic       halt_dev;
    logic       halt_phase;
    logic [8:0] sectors;
  } acb_xfer_req_t;

endpackage : acb_pkg

// file: core/acb_decoder.sv
// command block decoder: AXI4-Lite registers plus taskfile access sequencer
// assumes taskfile engine and data mover run on aclk; usb speed pin is async
//
// Summary of operation
// - only full speed 12 Mbit/s and high speed 480 Mbit/s are reported
// - block is an ATA command block only if first two bytes match signature
// - byte 0 must equal configured signature byte
// - action bit 7 flags identify data phase; host sets it only then
// - action bit 6 picks PIO (0) or Ultra DMA (1) transfers
// - action bit 5 picks device bit from config or byte 0x0B bit 4
// - action bits 4:3 choose halting on device and phase errors
// - action bit 2 clear means poll alternate status until not busy
// - action bit 1 puts device selection before or after the command write
// - action bit 0 reads selected registers only, eight bytes, zeros elsewhere
// - readback bytes 0..7 follow register order alt status through status
// - byte 3 selects registers, accessed in ascending bit order
// - block count must be 0 or a power of two 1,2,4,..,128; zero means 256; else fail
// - bytes 5..12 hold write values device control through command
// - unselected write bytes are never used
// - non-ATA blocks go to the storage command translator
`timescale 1ns/1ps
module acb_decoder
  import acb_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // usb speed indication from the phy pin
  input  wire logic          usb_high_speed_pin,
  // taskfile register access
  output logic               tf_req,
  output acb_tf_req_t        tf_cmd,
  input  wire logic          tf_done,
  input  wire logic [7:0]    tf_rdata,
  // data phase
  output logic               xfer_start,
  output acb_xfer_req_t      xfer_cmd,
  input  wire logic          xfer_done,
  input  wire logic          xfer_dev_err,
  input  wire logic          xfer_phase_err,
  // hand-off of other command blocks
  output logic               translate_req
);

  // ==========================================================
  // helpers
  function automatic logic blk_legal(input logic [7:0] c);
    blk_legal = (c & (c - 8'h01)) == 8'h00;
  endfunction : blk_legal

  function automatic logic [8:0] blk_sectors(input logic [7:0] c);
    blk_sectors = (c == 8'h00) ? BLK_ZERO_MEANS : {1'b0, c};
  endfunction : blk_sectors

  // ==========================================================
  // state
  logic [7:0]  cfg_sig;
  logic        cfg_dev;
  logic [7:0]  cb [0:15];
  logic [7:0]  rb [0:7];
  logic        st_busy;
  logic        st_done;
  logic        st_fail;
  logic        st_other;
  logic        st_halted;
  logic        hs_meta;
  logic        hs_sync;
  logic        go;
  acb_state_t  state;
  logic [2:0]  idx;

  logic [7:0]  act;
  logic [7:0]  rsel;
  logic [7:0]  dev_byte;
  logic        rdonly;
  logic        sel_after;
  logic        skip_idx;

  assign act       = cb[CB_ACTION];
  assign rsel      = cb[CB_REGSEL];
  assign rdonly    = act[ACT_READBACK];
  assign sel_after = act[ACT_SEL_AFTER] & ~rdonly;
  // device bit comes from config or the command block itself
  assign dev_byte  = {cb[CB_DEVICE][7:5],
                      act[ACT_DEV_SRC] ? cb[CB_DEVICE][DEVHEAD_DEV_BIT] : cfg_dev,
                      cb[CB_DEVICE][3:0]};
  // device/head write is deferred to after the command write
  assign skip_idx  = sel_after && (idx == REG_DEVHEAD);

  // ==========================================================
  // speed pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_meta <= 1'b0;
      hs_sync <= 1'b0;
    end else begin
      hs_meta <= usb_high_speed_pin;
      hs_sync <= hs_meta;
    end
  end

  // ==========================================================
  // axi write channel: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_hit;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit  = (aw_addr == OFS_CTRL) || (aw_addr == OFS_CMD) ||
                   (aw_addr >= OFS_CB0 && aw_addr <= OFS_CB3 && aw_addr[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software-written registers; block bytes frozen while busy
  assign go = wr_fire && (aw_addr == OFS_CMD) && w_strb[0] && w_data[CMD_GO_BIT] && !st_busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_sig <= CTRL_SIG_RESET;
      cfg_dev <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        cb[i] <= 8'h00;
      end
    end else if (wr_fire && !st_busy) begin
      if (aw_addr == OFS_CTRL) begin
        if (w_strb[0]) cfg_sig <= w_data[7:0];
        if (w_strb[1]) cfg_dev <= w_data[CTRL_DEV_BIT];
      end
      if (aw_addr >= OFS_CB0 && aw_addr <= OFS_CB3 && aw_addr[1:0] == 2'b00) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            cb[{aw_addr[3:2], 2'(b)}] <= w_data[8*b +: 8];
          end
        end
      end
    end
  end

  // ==========================================================
  // axi read channel
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:   rd_word = {23'h0, cfg_dev, cfg_sig};
      OFS_CMD:    rd_word = 32'h0000_0000;
      OFS_STATUS: rd_word = {26'h0, hs_sync, st_halted, st_other, st_fail, st_done, st_busy};
      8'h10:      rd_word = {cb[3], cb[2], cb[1], cb[0]};
      8'h14:      rd_word = {cb[7], cb[6], cb[5], cb[4]};
      8'h18:      rd_word = {cb[11], cb[10], cb[9], cb[8]};
      OFS_CB3:    rd_word = {cb[15], cb[14], cb[13], cb[12]};
      OFS_RB0:    rd_word = {rb[3], rb[2], rb[1], rb[0]};
      OFS_RB1:    rd_word = {rb[7], rb[6], rb[5], rb[4]};
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= ST_IDLE;
      idx           <= 3'h0;
      st_busy       <= 1'b0;
      st_done       <= 1'b0;
      st_fail       <= 1'b0;
      st_other      <= 1'b0;
      st_halted     <= 1'b0;
      tf_req        <= 1'b0;
      tf_cmd        <= '0;
      xfer_start    <= 1'b0;
      xfer_cmd      <= '0;
      translate_req <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rb[i] <= 8'h00;
      end
    end else begin
      xfer_start    <= 1'b0;
      translate_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go) begin
            st_busy   <= 1'b1;
            st_done   <= 1'b0;
            st_fail   <= 1'b0;
            st_other  <= 1'b0;
            st_halted <= 1'b0;
            idx       <= 3'h0;
            for (int i = 0; i < 8; i++) begin
              rb[i] <= 8'h00;
            end
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (cb[0] != cfg_sig || cb[1] != SUBCMD_ATA) begin
            st_other      <= 1'b1;
            translate_req <= 1'b1;
            state         <= ST_DONE;
          end else if (!blk_legal(cb[CB_BLKCNT])) begin
            st_fail <= 1'b1;
            state   <= ST_DONE;
          end else if (!act[ACT_SKIP_POLL]) begin
            state <= ST_POLL_REQ;
          end else begin
            state <= ST_ACC_REQ;
          end
        end
        ST_POLL_REQ: begin
          tf_req <= 1'b1;
          tf_cmd <= '{we: 1'b0, reg_idx: REG_ALTSTAT, wdata: 8'h00};
          state  <= ST_POLL_WAIT;
        end
        ST_POLL_WAIT: begin
          if (tf_done) begin
            tf_req <= 1'b0;
            state  <= tf_rdata[BSY_BIT] ? ST_POLL_REQ : ST_ACC_REQ;
          end
        end
        ST_ACC_REQ: begin
          if (rsel[idx] && !skip_idx) begin
            tf_req <= 1'b1;
            tf_cmd <= '{we: !rdonly, reg_idx: idx,
                        wdata: (idx == REG_DEVHEAD) ? dev_byte : cb[CB_WR_BASE + int'(idx)]};
            state  <= ST_ACC_WAIT;
          end else if (idx == REG_LAST) begin
            state <= rdonly ? ST_DONE : (sel_after && rsel[REG_DEVHEAD]) ? ST_SEL_REQ : ST_XFER;
          end else begin
            idx <= idx + 3'h1;
          end
        end
        ST_ACC_WAIT: begin
          if (tf_done) begin
            tf_req <= 1'b0;
            if (rdonly) begin
              rb[idx] <= tf_rdata;
            end
            if (idx == REG_LAST) begin
              state <= rdonly ? ST_DONE : (sel_after && rsel[REG_DEVHEAD]) ? ST_SEL_REQ : ST_XFER;
            end else begin
              idx   <= idx + 3'h1;
              state <= ST_ACC_REQ;
            end
          end
        end
        ST_SEL_REQ: begin
          tf_req <= 1'b1;
          tf_cmd <= '{we: 1'b1, reg_idx: REG_DEVHEAD, wdata: dev_byte};
          state  <= ST_SEL_WAIT;
        end
        ST_SEL_WAIT: begin
          if (tf_done) begin
            tf_req <= 1'b0;
            state  <= ST_XFER;
          end
        end
        ST_XFER: begin
          xfer_start <= 1'b1;
          xfer_cmd   <= '{udma:       act[ACT_UDMA],
                          identify:   act[ACT_IDENTIFY],
                          halt_dev:   !act[ACT_HALT_DEV],
                          halt_phase: !act[ACT_HALT_PHASE],
                          sectors:    blk_sectors(cb[CB_BLKCNT])};
          state      <= ST_XFER_WAIT;
        end
        ST_XFER_WAIT: begin
          if (xfer_done) begin
            if ((xfer_dev_err && xfer_cmd.halt_dev) || (xfer_phase_err && xfer_cmd.halt_phase)) begin
              st_halted <= 1'b1;
              st_fail   <= 1'b1;
            end
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_busy <= 1'b0;
          st_done <= 1'b1;
          state   <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : acb_decoder

// file: test/acb_decoder_asserts.sv
// port checker for the command block decoder, bound to every instance
// assumes one aclk domain and the synchronous active-low aresetn
`timescale 1ns/1ps
module acb_decoder_asserts
  import acb_pkg::*;
(
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // taskfile side
  input wire logic          tf_req,
  input wire acb_tf_req_t   tf_cmd,
  input wire logic          tf_done,
  // data phase and hand-off
  input wire logic          xfer_start,
  input wire acb_xfer_req_t xfer_cmd,
  input wire logic          translate_req
);
  default clocking cb_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // taskfile handshake
  sequence s_tf_wait; tf_req && !tf_done; endsequence
  sequence s_tf_acc;  tf_req && tf_done;  endsequence

  AST_TF_HOLD: assert property (s_tf_wait |=> tf_req && $stable(tf_cmd))
    else $error("taskfile request changed before done");
  AST_TF_GAP: assert property (s_tf_acc |=> !tf_req)
    else $error("taskfile request not dropped after done");

  // ==========================================================
  // data phase
  AST_XSTART_PULSE: assert property (xfer_start |=> !xfer_start)
    else $error("data phase start longer than one cycle");
  AST_XSECT: assert property (xfer_start |-> $onehot(xfer_cmd.sectors))
    else $error("block size not a legal power of two");
  AST_XIDLE: assert property (xfer_start |-> !tf_req && !translate_req)
    else $error("data phase started during register access");
  AST_XLAST: assert property (xfer_start |=> !tf_req [*5])
    else $error("register access after data phase start");
  AST_XCMD_HOLD: assert property (xfer_start |=> $stable(xfer_cmd) [*3])
    else $error("data phase settings changed");

  // ==========================================================
  // other command blocks
  AST_TRANS: assert property (translate_req |=> (!tf_req && !xfer_start) [*4])
    else $error("drive touched for a non-ATA block");
endmodule : acb_decoder_asserts

bind acb_decoder acb_decoder_asserts u_asserts (.aclk, .aresetn, .tf_req, .tf_cmd, .tf_done,
  .xfer_start, .xfer_cmd, .translate_req);

// file: test/acb_decoder_test.sv
// self-checking bench for the command block decoder
// assumes acb_pkg, the checker and the drive model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module acb_decoder_test
  import acb_pkg::*;
;
  logic          aclk = 1'b0, aresetn = 1'b0, spd = 1'b0, slow = 1'b0, arm = 1'b0, dev_cfg = 1'b1;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00, sig = 8'h5A, tf_rdata, cb [16];
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]   wdata = 32'h0, rdata, rdat, seed = 32'd32;
  logic          awready, wready, bvalid, arready, rvalid, tf_req, tf_done, xfer_start;
  logic          xfer_done, dev_err, ph_err, translate_req;
  logic [1:0]    bresp, rresp, resp, bsy = 2'h0, err_set = 2'h0;
  acb_tf_req_t   tf_cmd, tlog [$], eq [$];
  acb_xfer_req_t xfer_cmd, xgot;
  int            n_fail = 0, samples_checked = 0, xseen = 0, nsig = 0, tno = 0;

  always #20 aclk = ~aclk;

  acb_decoder u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .usb_high_speed_pin(spd),
    .tf_req, .tf_cmd, .tf_done, .tf_rdata, .xfer_start, .xfer_cmd, .xfer_done,
    .xfer_dev_err(dev_err), .xfer_phase_err(ph_err), .translate_req);

  acb_drive_model u_drive (.aclk, .aresetn, .tf_req, .tf_cmd, .tf_done, .tf_rdata, .xfer_start,
    .xfer_done, .xfer_dev_err(dev_err), .xfer_phase_err(ph_err), .slow, .arm, .bsy_reads(bsy), .err_set);

  // reads keep only kind and index; their data byte is don't-care
  always @(posedge aclk) begin
    if (tf_req && tf_done) tlog.push_back({tf_cmd.we, tf_cmd.reg_idx, tf_cmd.we ? tf_cmd.wdata : 8'h00});
    if (xfer_start) begin
      xseen++;
      xgot = xfer_cmd;
    end
    if (translate_req) nsig++;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic void build_exp(input logic good);
    logic [7:0] act, dh;
    act = cb[CB_ACTION];
    dh = cb[CB_DEVICE];
    dh[DEVHEAD_DEV_BIT] = act[ACT_DEV_SRC] ? cb[CB_DEVICE][4] : dev_cfg;
    eq.delete();
    if (good && !act[ACT_SKIP_POLL]) for (int i = 0; i <= bsy; i++) eq.push_back(12'h000);
    for (int i = 0; i < 8; i++) begin
      if (good && cb[CB_REGSEL][i]) begin
        if (act[ACT_READBACK]) eq.push_back({1'b0, 3'(i), 8'h00});
        else if (i == 6 && !act[ACT_SEL_AFTER]) eq.push_back({4'hE, dh});
        else if (i != 6) eq.push_back({1'b1, 3'(i), cb[CB_WR_BASE + i]});
      end
    end
    if (good && cb[CB_REGSEL][6] && act[ACT_SEL_AFTER] && !act[0]) eq.push_back({4'hE, dh});
  endfunction : build_exp

  function automatic logic [31:0] rb_exp(input int k);
    logic [31:0] v;
    for (int j = 0; j < 4; j++) v[8*j +: 8] = cb[CB_REGSEL][4*k+j] ? {5'h0A, 3'(4*k+j)} : 8'h00;
    return v;
  endfunction : rb_exp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    arm     <= 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic run(input logic ok_sig);
    logic [7:0] act;
    logic [8:0] sec;
    logic       good, fail, halt;
    act = cb[CB_ACTION];
    sec = (cb[CB_BLKCNT] == 8'h00) ? BLK_ZERO_MEANS : {1'b0, cb[CB_BLKCNT]};
    good = ok_sig && $onehot(sec);
    halt = good && !act[0] && |(err_set & ~act[4:3]);
    fail = (ok_sig && !good) || halt;
    for (int k = 0; k < 4; k++) axi_wr(OFS_CB0 + 8'(4 * k), {cb[4*k+3], cb[4*k+2], cb[4*k+1], cb[4*k]});
    build_exp(good);
    tlog.delete();
    xseen = 0;
    nsig = 0;
    arm <= 1'b1;
    axi_wr(OFS_CMD, 32'h1);
    do axi_rd(OFS_STATUS); while (rdat[0]);
    `CHK(rdat, {26'h0, spd, halt, !ok_sig, fail, 2'b10})
    `CHK(rdat[4], halt)
    `CHK(nsig, ok_sig ? 0 : 1)
    `CHK(tlog.size(), eq.size())
    foreach (eq[i]) if (i < tlog.size()) `CHK(tlog[i], eq[i])
    `CHK(xseen, (good && !act[0]) ? 1 : 0)
    if (xseen == 1) `CHK(xgot, {act[ACT_UDMA], act[ACT_IDENTIFY], ~act[4], ~act[3], sec})
    for (int k = 0; k < 2 && good && act[0]; k++) begin
      axi_rd(OFS_RB0 + 8'(4 * k));
      `CHK(rdat, rb_exp(k))
    end
    $display("test %0d ended, mismatches so far %0d", tno++, n_fail);
  endtask : run

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // stimulus
  initial begin
    spd <= 1'(rnd() % 2);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(OFS_CTRL);
    `CHK({resp, rdat}, {RESP_OKAY, 32'h0})
    axi_rd(8'h40);
    `CHK({resp, rdat}, {RESP_SLVERR, 32'h0})
    axi_wr(OFS_CTRL, {23'h0, dev_cfg, sig});
    `CHK(resp, RESP_OKAY)
    axi_wr(8'h40, 32'hFFFF_FFFF);
    `CHK(resp, RESP_SLVERR)
    for (int n = 0; n < 19; n++) begin
      foreach (cb[i]) cb[i] = 8'(rnd());
      cb[0] = (n == 18) ? ~sig : sig;
      cb[1] = (n == 17) ? 8'h25 : SUBCMD_ATA;
      cb[CB_BLKCNT] = (n == 0) ? 8'h00 : (n == 16) ? 8'h03 : 8'(1 << (rnd() % 8));
      cb[CB_ACTION][4:3] = 2'(n);
      cb[CB_ACTION][0] = (n % 4 == 0);
      if (n < 3) cb[CB_REGSEL] = 8'hFF;
      if (n < 3) cb[CB_ACTION][1] = n[0];
      {cb[13], cb[14], cb[15]} = 24'h0;
      bsy = cb[CB_ACTION][2] ? 2'h0 : 2'(rnd());
      slow = 1'(rnd() % 2);
      err_set = 2'(rnd());
      run(n < 17);
    end
    end_of_test();
  end

  // run needs about 1200 cycles; cut off far beyond that
  initial begin
    #(40 * 30000);
    n_fail++;
    end_of_test();
  end
endmodule : acb_decoder_test

// file: test/acb_drive_model.sv
// drive-side model: taskfile engine and data mover behind the decoder
// assumes same aclk; taskfile answers after 1 or 5 cycles, data mover after 2 or 6, as slow says
`timescale 1ns/1ps
module acb_drive_model
  import acb_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // taskfile side
  input wire logic        tf_req,
  input wire acb_tf_req_t tf_cmd,
  output logic            tf_done,
  output logic [7:0]      tf_rdata,
  // data phase
  input wire logic        xfer_start,
  output logic            xfer_done,
  output logic            xfer_dev_err,
  output logic            xfer_phase_err,
  // scenario controls
  input wire logic        slow,
  input wire logic        arm,
  input wire logic [1:0]  bsy_reads,
  input wire logic [1:0]  err_set
);
  logic [2:0] wcnt;
  logic [2:0] xwait;
  logic [1:0] bsy_left;
  logic       hit;

  assign hit = aresetn && tf_req && !tf_done && wcnt == (slow ? 3'h4 : 3'h0);

  // ==========================================================
  // taskfile answers
  always_ff @(posedge aclk) begin
    tf_done <= hit;
    if (!aresetn || !tf_req || tf_done) begin
      wcnt <= 3'h0;
    end else if (!hit) begin
      wcnt <= wcnt + 3'h1;
    end
  end

  // data held only with done; inverted otherwise so stale values never match
  always_ff @(posedge aclk) begin
    if (arm) begin
      bsy_left <= bsy_reads;
    end else if (hit && tf_cmd.reg_idx == REG_ALTSTAT && bsy_left != 2'h0) begin
      bsy_left <= bsy_left - 2'h1;
    end
    if (hit && tf_cmd.reg_idx == REG_ALTSTAT && bsy_left != 2'h0) begin
      tf_rdata <= 8'h80;
    end else if (hit) begin
      tf_rdata <= {5'h0A, tf_cmd.reg_idx};
    end else begin
      tf_rdata <= ~tf_rdata;
    end
  end

  // ==========================================================
  // data phase
  always_ff @(posedge aclk) begin
    xfer_done <= 1'b0;
    {xfer_dev_err, xfer_phase_err} <= ~err_set;
    if (!aresetn) begin
      xwait <= 3'h0;
    end else if (xfer_start) begin
      xwait <= slow ? 3'h5 : 3'h1;
    end else if (xwait != 3'h0) begin
      xwait <= xwait - 3'h1;
      if (xwait == 3'h1) begin
        xfer_done <= 1'b1;
        {xfer_dev_err, xfer_phase_err} <= err_set;
      end
    end
  end
endmodule : acb_drive_model
